/* File: design/srp_pkg.sv */
// Purpose: constants and types for serial encoder position referencing
// Assumes: 32-bit classic Wishbone, word aligned registers
// Notes: positions are signed 32-bit counts
package srp_pkg;
  // ***************
  // register offsets
  // ***************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ERR = 8'h0C;
  localparam logic [7:0] OFS_HOME_POS = 8'h10;
  localparam logic [7:0] OFS_PRESET = 8'h14;
  localparam logic [7:0] OFS_OFFSET = 8'h18;
  localparam logic [7:0] OFS_ACT_POS = 8'h1C;
  localparam logic [7:0] OFS_LOW_LIM = 8'h20;
  localparam logic [7:0] OFS_RANGE = 8'h24;
  localparam logic [7:0] OFS_POS_LIM = 8'h28;
  localparam logic [7:0] OFS_NEG_LIM = 8'h2C;
  localparam logic [7:0] OFS_CMD_POS = 8'h30;
  // ***************
  // field positions
  // ***************
  localparam int CTRL_ABS = 0;
  localparam int CTRL_LOWBAT_EN = 1;
  localparam int CTRL_ROTARY = 2;
  localparam int CMD_HOME_POS = 0;
  localparam int CMD_HOME_NEG = 1;
  localparam int CMD_HOME_SW = 2;
  localparam int CMD_PRESET = 3;
  localparam int CMD_HALT = 4;
  // ***************
  // error codes and reset values
  // ***************
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_NOT_REF = 16'h0053;
  localparam logic [15:0] ERR_LOW_BATT = 16'h00C1;
  localparam logic [15:0] ERR_BATT_LOST = 16'h00C2;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [2:0] RST_CTRL = 3'h0;
  // ***************
  // types
  // ***************
  typedef struct packed {
    logic [31:0] pos;
    logic referenced;
    logic marker;
    logic low_batt;
    logic batt_lost;
    logic alarm;
  } srp_enc_t;
  typedef enum logic [1:0] {
    HM_POS = 2'h0,
    HM_NEG = 2'h1,
    HM_SW = 2'h2
  } srp_hmode_t;
  typedef enum logic [3:0] {
    ST_WAIT = 4'b0001,
    ST_QUERY = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_HOME = 4'b1000
  } srp_state_t;
endpackage

/* File: design/srp_top.sv */
// Purpose: position referencing for an axis on a serial encoder
// Assumes: encoder inputs synchronous to CLK, one clock of 25 MHz
// Notes: OFFSET may be preloaded by software before DIAG_DONE
// How it works
// RULE1 - control bit picks incremental or absolute mode
// RULE2 - incremental: marker pulse once per revolution
// RULE3 - incremental: home or preset sets valid
// RULE4 - incremental: travel limits enforced, position wraps
// RULE5 - software homes absolute axis after battery loss
// RULE6 - encoder reports referenced after one revolution
// RULE7 - homing by plus move, minus move, switch
// RULE8 - absolute home: actual equals home, offset stored
// RULE9 - homing start clears valid until completion
// RULE10 - halt during homing leaves valid cleared
// RULE11 - absolute preset: offset gives commanded position
// RULE12 - absolute preset before referenced: error 53
// RULE13 - successful absolute preset sets valid
// RULE14 - battery alarm enabled: errors C1, C2
// RULE15 - power-up: check referenced, then read position
// RULE16 - actual position is encoder plus offset
// RULE17 - no auto-restore on alarm, unreferenced, reconfig
// RULE18 - failed restore loads default zero if allowed
// RULE19 - rotary default: low limit plus half range
// RULE20 - linear default: negative limit plus half span
// RULE21 - valid held low from reset until referenced
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
module srp_top
  import srp_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // encoder and machine
  input wire srp_enc_t ENC,
  input wire logic HOME_SWITCH,
  input wire logic DIAG_DONE,
  input wire logic CFG_CHANGED,
  // axis outputs
  output logic POS_VALID,
  output logic MOVE_POS,
  output logic MOVE_NEG,
  output logic LIMIT_HIT
);
  // ***************
  // state
  // ***************
  srp_state_t state, next_state;
  srp_hmode_t hmode, next_hmode;
  logic [2:0] ctrl, next_ctrl;
  logic [15:0] err, next_err;
  logic [31:0] home_pos, next_home_pos;
  logic [31:0] preset, next_preset;
  logic [31:0] offset, next_offset;
  logic [31:0] low_lim, next_low_lim;
  logic [31:0] range, next_range;
  logic [31:0] pos_lim, next_pos_lim;
  logic [31:0] neg_lim, next_neg_lim;
  logic [31:0] cmd_pos, next_cmd_pos;
  logic [31:0] dat, next_dat;
  logic ack, next_ack;
  logic valid, next_valid;
  logic mv_pos, next_mv_pos;
  logic mv_neg, next_mv_neg;
  logic lim, next_lim;
  logic sw_q, next_sw_q;

  // ***************
  // helpers
  // ***************
  function automatic logic [31:0] lane(input logic [31:0] old, input logic [31:0] wd,
                                       input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] dflt_pos(input logic rot, input logic [31:0] lo,
                                           input logic [31:0] rg, input logic [31:0] pl,
                                           input logic [31:0] nl);
    logic [31:0] r;
    r = RST_ZERO;
    if (rot) begin
      if (($signed(lo) > 0) || ($signed(lo + rg) <= 0)) begin
        r = lo + {rg[31], rg[31:1]}; // RULE19
      end
    end else begin
      if (($signed(nl) > 0) || ($signed(pl) < 0)) begin
        r = nl + ((pl - nl) >> 1); // RULE20
      end
    end
    return r;
  endfunction

  logic abs_mode;
  logic [31:0] act_pos;
  logic [31:0] dflt;
  logic bus_req;
  logic bus_wr;
  logic cmd_wr;
  logic [4:0] cmd;
  logic home_req;
  logic home_done;
  logic restore_ok;
  logic preset_ok;
  logic preset_bad;
  logic sw_rise;
  logic [31:0] ctrl_wr;

  assign abs_mode = ctrl[CTRL_ABS]; // RULE1
  assign ctrl_wr = lane({29'h0, ctrl}, WB_DAT_I, WB_SEL_I);
  assign act_pos = ENC.pos + offset; // RULE16 RULE4
  assign dflt = dflt_pos(ctrl[CTRL_ROTARY], low_lim, range, pos_lim, neg_lim);
  assign bus_req = WB_CYC_I && WB_STB_I && !ack;
  assign bus_wr = bus_req && WB_WE_I;
  assign cmd_wr = bus_wr && (WB_ADR_I == OFS_CMD) && WB_SEL_I[0];
  assign cmd = cmd_wr ? WB_DAT_I[4:0] : 5'h00;
  assign home_req = (state == ST_IDLE) && !cmd[CMD_HALT] &&
                    (cmd[CMD_HOME_POS] || cmd[CMD_HOME_NEG] || cmd[CMD_HOME_SW]); // RULE7
  assign sw_rise = HOME_SWITCH && !sw_q;
  assign home_done = (state == ST_HOME) && !cmd[CMD_HALT] &&
                     ((hmode == HM_SW) ? sw_rise : ENC.marker); // RULE2
  assign preset_bad = (state == ST_IDLE) && cmd[CMD_PRESET] && abs_mode &&
                      !ENC.referenced; // RULE12
  assign preset_ok = (state == ST_IDLE) && cmd[CMD_PRESET] && !cmd[CMD_HALT] &&
                     !home_req && !preset_bad;
  assign restore_ok = ENC.referenced && !ENC.alarm && !CFG_CHANGED; // RULE17 RULE6

  // ***************
  // next values
  // ***************
  always_comb begin
    next_state = state;
    next_hmode = hmode;
    next_ctrl = ctrl;
    next_err = err;
    next_home_pos = home_pos;
    next_preset = preset;
    next_offset = offset;
    next_low_lim = low_lim;
    next_range = range;
    next_pos_lim = pos_lim;
    next_neg_lim = neg_lim;
    next_cmd_pos = cmd_pos;
    next_valid = valid;
    next_ack = bus_req;
    next_dat = RST_ZERO;
    next_sw_q = HOME_SWITCH;
    // register writes
    if (bus_wr) begin
      unique case (WB_ADR_I)
        OFS_CTRL: next_ctrl = ctrl_wr[2:0];
        OFS_ERR: next_err = RST_ZERO[15:0];
        OFS_HOME_POS: next_home_pos = lane(home_pos, WB_DAT_I, WB_SEL_I);
        OFS_PRESET: next_preset = lane(preset, WB_DAT_I, WB_SEL_I);
        OFS_OFFSET: next_offset = lane(offset, WB_DAT_I, WB_SEL_I);
        OFS_LOW_LIM: next_low_lim = lane(low_lim, WB_DAT_I, WB_SEL_I);
        OFS_RANGE: next_range = lane(range, WB_DAT_I, WB_SEL_I);
        OFS_POS_LIM: next_pos_lim = lane(pos_lim, WB_DAT_I, WB_SEL_I);
        OFS_NEG_LIM: next_neg_lim = lane(neg_lim, WB_DAT_I, WB_SEL_I);
        OFS_CMD_POS: next_cmd_pos = lane(cmd_pos, WB_DAT_I, WB_SEL_I);
        default: next_err = err;
      endcase
    end
    // read data
    if (bus_req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        OFS_CTRL: next_dat = {29'h0, ctrl};
        OFS_STATUS: next_dat = {26'h0, ENC.referenced, state == ST_HOME,
                                state == ST_IDLE, lim, hmode == HM_SW, valid};
        OFS_ERR: next_dat = {16'h0, err};
        OFS_HOME_POS: next_dat = home_pos;
        OFS_PRESET: next_dat = preset;
        OFS_OFFSET: next_dat = offset;
        OFS_ACT_POS: next_dat = act_pos;
        OFS_LOW_LIM: next_dat = low_lim;
        OFS_RANGE: next_dat = range;
        OFS_POS_LIM: next_dat = pos_lim;
        OFS_NEG_LIM: next_dat = neg_lim;
        OFS_CMD_POS: next_dat = cmd_pos;
        default: next_dat = RST_ZERO;
      endcase
    end
    // sequencing
    unique case (state)
      ST_WAIT: begin
        if (DIAG_DONE) begin
          next_state = abs_mode ? ST_QUERY : ST_IDLE; // RULE15
        end
      end
      ST_QUERY: begin
        next_state = ST_IDLE;
        if (restore_ok) begin
          next_valid = 1'b1; // RULE15
          next_cmd_pos = act_pos;
        end else begin
          next_offset = dflt - ENC.pos; // RULE18
          next_cmd_pos = dflt; // RULE18
        end
      end
      ST_IDLE: begin
        if (home_req) begin
          next_state = ST_HOME;
          next_valid = 1'b0; // RULE9
          next_hmode = cmd[CMD_HOME_POS] ? HM_POS : (cmd[CMD_HOME_NEG] ? HM_NEG : HM_SW);
        end else if (preset_ok) begin
          next_offset = preset - ENC.pos; // RULE11 RULE3
          next_cmd_pos = preset;
          next_valid = 1'b1; // RULE13 RULE3
        end
      end
      ST_HOME: begin
        if (cmd[CMD_HALT]) begin
          next_state = ST_IDLE;
          next_valid = 1'b0; // RULE10
        end else if (home_done) begin
          next_state = ST_IDLE;
          next_offset = home_pos - ENC.pos; // RULE8 RULE3
          next_cmd_pos = home_pos;
          next_valid = 1'b1; // RULE8 RULE3
        end
      end
    endcase
    // errors: hardware event wins over the clear
    if (preset_bad) begin
      next_err = ERR_NOT_REF; // RULE12
    end
    if (ctrl[CTRL_LOWBAT_EN] && ENC.low_batt) begin
      next_err = ERR_LOW_BATT; // RULE14
    end
    if (ctrl[CTRL_LOWBAT_EN] && ENC.batt_lost) begin
      next_err = ERR_BATT_LOST; // RULE14
    end
  end

  // travel limit and motion requests
  always_comb begin
    next_lim = !abs_mode && (($signed(act_pos) >= $signed(pos_lim)) ||
                            ($signed(act_pos) <= $signed(neg_lim))); // RULE4
    next_mv_pos = (next_state == ST_HOME) && (next_hmode != HM_NEG) &&
                  !(!abs_mode && ($signed(act_pos) >= $signed(pos_lim))); // RULE4
    next_mv_neg = (next_state == ST_HOME) && (next_hmode == HM_NEG) &&
                  !(!abs_mode && ($signed(act_pos) <= $signed(neg_lim))); // RULE4
  end

  // ***************
  // registers
  // ***************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_WAIT;
      hmode <= HM_POS;
      ctrl <= RST_CTRL;
      err <= ERR_NONE;
      home_pos <= RST_ZERO;
      preset <= RST_ZERO;
      offset <= RST_ZERO;
      low_lim <= RST_ZERO;
      range <= RST_ZERO;
      pos_lim <= RST_ZERO;
      neg_lim <= RST_ZERO;
      cmd_pos <= RST_ZERO;
      dat <= RST_ZERO;
      ack <= 1'b0;
      valid <= 1'b0; // RULE21
      mv_pos <= 1'b0;
      mv_neg <= 1'b0;
      lim <= 1'b0;
      sw_q <= 1'b0;
    end else begin
      state <= next_state;
      hmode <= next_hmode;
      ctrl <= next_ctrl;
      err <= next_err;
      home_pos <= next_home_pos;
      preset <= next_preset;
      offset <= next_offset;
      low_lim <= next_low_lim;
      range <= next_range;
      pos_lim <= next_pos_lim;
      neg_lim <= next_neg_lim;
      cmd_pos <= next_cmd_pos;
      dat <= next_dat;
      ack <= next_ack;
      valid <= next_valid;
      mv_pos <= next_mv_pos;
      mv_neg <= next_mv_neg;
      lim <= next_lim;
      sw_q <= next_sw_q;
    end
  end

  assign WB_DAT_O = dat;
  assign WB_ACK_O = ack;
  assign POS_VALID = valid;
  assign MOVE_POS = mv_pos;
  assign MOVE_NEG = mv_neg;
  assign LIMIT_HIT = lim;

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  home_clears_a: assert property (home_req |=> !valid && state == ST_HOME) // RULE9
    else $error("homing start did not clear valid");

  halt_keeps_a: assert property ((state == ST_HOME) && cmd[CMD_HALT] // RULE10
                                 |=> !valid && state == ST_IDLE ##1 !valid)
    else $error("halt left valid set");

  preset_rej_a: assert property (preset_bad && !ctrl[CTRL_LOWBAT_EN] // RULE12
                                 |=> err == ERR_NOT_REF && !$rose(valid))
    else $error("unreferenced preset not rejected");

  preset_off_a: assert property (preset_ok // RULE11
                                 |=> valid && offset == $past(preset) - $past(ENC.pos))
    else $error("preset offset wrong");

  home_off_a: assert property (home_done // RULE8
                               |=> valid && cmd_pos == $past(home_pos)
                               && offset == $past(home_pos) - $past(ENC.pos))
    else $error("home offset wrong");

  batt_err_a: assert property (ctrl[CTRL_LOWBAT_EN] && ENC.low_batt && !ENC.batt_lost // RULE14
                               |=> err == ERR_LOW_BATT)
    else $error("low battery not reported");

  batt_lost_a: assert property (ctrl[CTRL_LOWBAT_EN] && ENC.batt_lost // RULE14
                                |=> err == ERR_BATT_LOST)
    else $error("battery loss not reported");

  no_restore_a: assert property ((state == ST_QUERY) && !restore_ok // RULE17
                                 |=> !valid && cmd_pos == $past(dflt))
    else $error("bad restore set valid");

  restore_set_a: assert property ((state == ST_QUERY) && restore_ok // RULE15
                                  |=> valid && cmd_pos == $past(act_pos))
    else $error("good restore left valid low");

  valid_cause_a: assert property ($rose(valid) // RULE21
                                  |-> $past(home_done) || $past(preset_ok)
                                  || ($past(state) == ST_QUERY && $past(restore_ok)))
    else $error("valid rose without cause");

  query_first_a: assert property ((state == ST_WAIT) && DIAG_DONE && abs_mode // RULE15
                                  |=> state == ST_QUERY ##1 state == ST_IDLE)
    else $error("power-up query skipped");

  incr_skip_a: assert property ((state == ST_WAIT) && DIAG_DONE && !abs_mode // RULE1
                                |=> state == ST_IDLE && !valid)
    else $error("incremental power-up not idle");

  home_dir_a: assert property (home_req && cmd[CMD_HOME_NEG] && !cmd[CMD_HOME_POS] // RULE7
                               |=> hmode == HM_NEG && state == ST_HOME)
    else $error("minus homing mode not taken");

  limit_stop_a: assert property (!abs_mode && ($signed(act_pos) >= $signed(pos_lim)) // RULE4
                                 |=> !mv_pos && lim)
    else $error("motion past upper limit");

  limit_low_a: assert property (!abs_mode && ($signed(act_pos) <= $signed(neg_lim)) // RULE4
                                |=> !mv_neg && lim)
    else $error("motion past lower limit");
endmodule

/* File: dv/srp_enc_model.sv */
// Purpose: behavioural serial encoder behind the amplifier
// Assumes: shaft turns one count per clock while a move is requested
// Notes: battery reset loses the referenced status and the count
`timescale 1ns/10ps
module srp_enc_model
  import srp_pkg::*;
#(
  parameter int REV = 16
)
(
  // clock and battery supply
  input wire logic clk,
  input wire logic batt_rst_n,
  // motion requests
  input wire logic move_pos,
  input wire logic move_neg,
  // fault injection
  input wire logic low_batt,
  input wire logic batt_lost,
  input wire logic alarm,
  // encoder frame
  output srp_enc_t enc
);
  logic [31:0] pos;
  logic [31:0] step;
  logic referenced;
  logic marker;
  assign step = move_pos ? 32'h1 : (move_neg ? 32'hFFFF_FFFF : 32'h0);
  assign enc = '{pos: pos, referenced: referenced, marker: marker, low_batt: low_batt,
    batt_lost: batt_lost, alarm: alarm};
  always_ff @(posedge clk or negedge batt_rst_n) begin
    if (!batt_rst_n) begin
      pos <= 32'h5;
      referenced <= 1'b0;
      marker <= 1'b0;
    end else begin
      pos <= pos + step;
      // once per revolution, also the internal reference point
      marker <= (step != 32'h0) && ((pos + step) % REV == 0);
      if ((step != 32'h0) && ((pos + step) % REV == 0)) begin
        referenced <= 1'b1;
      end
    end
  end
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for position referencing
// Assumes: encoder model on the far side, 25 MHz clock
// Notes: register rows first, then mode scenarios
`timescale 1ns/10ps
module tb_top;
  import srp_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [31:0] wr; logic [31:0] rd;} srp_row_t;
  logic clk, arst_n, batt_rst_n, cyc, stb, we, ack, home_sw, diag, sw_d;
  logic valid, mpos, mneg, lhit, low_batt, batt_lost, alarm, cfg_chg;
  logic [7:0] adr;
  logic [31:0] dati, dato, mark_pos;
  logic [1:0] hm;
  srp_enc_t enc;
  int bad_count, cmp_count;
  srp_row_t rows [11] = '{'{OFS_HOME_POS, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{OFS_PRESET, 32'h1234_5678, 32'h1234_5678}, '{OFS_OFFSET, 32'h8000_0001, 32'h8000_0001},
    '{OFS_LOW_LIM, 32'h8765_4321, 32'h8765_4321}, '{OFS_RANGE, 32'h0000_FFFF, 32'h0000_FFFF},
    '{OFS_POS_LIM, 32'h7FFF_FFFF, 32'h7FFF_FFFF}, '{OFS_NEG_LIM, 32'h8000_0000, 32'h8000_0000},
    '{OFS_CMD_POS, 32'hDEAD_BEEF, 32'hDEAD_BEEF}, '{OFS_CMD, 32'h0, 32'h0},
    '{8'h40, 32'hFFFF_FFFF, 32'h0}, '{OFS_CTRL, 32'h5, 32'h5}};
  srp_top srp_top_inst (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dati), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .ENC(enc), .HOME_SWITCH(home_sw), .DIAG_DONE(diag), .CFG_CHANGED(cfg_chg),
    .POS_VALID(valid), .MOVE_POS(mpos), .MOVE_NEG(mneg), .LIMIT_HIT(lhit));
  srp_enc_model srp_enc_model_inst (.clk(clk), .batt_rst_n(batt_rst_n), .move_pos(mpos),
    .move_neg(mneg), .low_batt(low_batt), .batt_lost(batt_lost), .alarm(alarm), .enc(enc));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // reference point of the last completed homing
  always @(posedge clk) begin
    if ((hm != 2'h2 && enc.marker) || (hm == 2'h2 && home_sw && !sw_d)) begin
      mark_pos <= enc.pos;
    end
    sw_d <= home_sw;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk32(q, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((mpos | mneg) !== 1'b0 && n < 200);
    if (n >= 200) begin
      chk1(1'b0, 1'b1);
      finish_test();
    end
  endtask
  task automatic do_reset(input logic lose_batt);
    @(posedge clk);
    arst_n <= 1'b0;
    batt_rst_n <= !lose_batt;
    diag <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    batt_rst_n <= 1'b1;
    @(posedge clk);
    chk1(valid, 1'b0);
  endtask
  task automatic start_diag;
    @(posedge clk);
    diag <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    #(40 * 20000);
    $display("Error at %0t: watchdog expired", $time);
    bad_count++;
    finish_test();
  end
  initial begin
    {arst_n, batt_rst_n, cyc, stb, we, home_sw, diag, low_batt, batt_lost, alarm, cfg_chg} = '0;
    {adr, dati, hm} = '0;
    do_reset(1'b1);
    // status shows the limit flag, actual position the encoder count
    for (int i = 0; i <= 12; i++) begin
      rdchk(8'(i * 4), (i == 2) ? 32'h4 : ((i == 7) ? 32'h5 : 32'h0));
    end
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wr);
      rdchk(rows[i].adr, rows[i].rd);
    end
    $display("test registers done");
    do_reset(1'b0);
    @(posedge clk);
    chk1(lhit, 1'b1);
    wr(OFS_POS_LIM, 32'd1000);
    wr(OFS_NEG_LIM, 32'hFFFF_FC18);
    start_diag();
    chk1(lhit, 1'b0);
    wr(OFS_PRESET, 32'h64);
    wr(OFS_CMD, 32'h8);
    @(posedge clk);
    chk1(valid, 1'b1);
    rdchk(OFS_ACT_POS, 32'h64);
    for (int m = 0; m < 3; m++) begin
      hm = 2'(m);
      wr(OFS_HOME_POS, 32'h200 + m);
      wr(OFS_CMD, 32'h1 << m);
      @(posedge clk);
      chk1(valid, 1'b0);
      chk1(m == 1 ? mneg : mpos, 1'b1);
      if (m == 2) begin
        repeat (5) @(posedge clk);
        home_sw <= 1'b1;
      end
      wait_idle();
      home_sw <= 1'b0;
      @(posedge clk);
      chk1(valid, 1'b1);
      rdchk(OFS_ACT_POS, enc.pos + 32'h200 + m - mark_pos);
    end
    wr(OFS_CMD, 32'h4);
    wr(OFS_CMD, 32'h10);
    repeat (3) @(posedge clk);
    chk1(valid, 1'b0);
    chk1(mpos, 1'b0);
    $display("test incremental done");
    hm = 2'h0;
    do_reset(1'b1);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_NEG_LIM, 32'd100);
    wr(OFS_POS_LIM, 32'd300);
    start_diag();
    chk1(valid, 1'b0);
    rdchk(OFS_CMD_POS, 32'd200);
    rdchk(OFS_ACT_POS, 32'd200);
    wr(OFS_PRESET, 32'h77);
    wr(OFS_CMD, 32'h8);
    rdchk(OFS_ERR, 32'h53);
    chk1(valid, 1'b0);
    wr(OFS_ERR, 32'h0);
    // battery was lost, so software homes the axis
    wr(OFS_HOME_POS, 32'h400);
    wr(OFS_CMD, 32'h1);
    wait_idle();
    @(posedge clk);
    chk1(valid, 1'b1);
    rdchk(OFS_ACT_POS, enc.pos + 32'h400 - mark_pos);
    wr(OFS_CMD, 32'h8);
    @(posedge clk);
    chk1(valid, 1'b1);
    rdchk(OFS_ACT_POS, 32'h77);
    rdchk(OFS_ERR, 32'h0);
    $display("test absolute homing done");
    do_reset(1'b0);
    wr(OFS_CTRL, 32'h7);
    wr(OFS_LOW_LIM, 32'd100);
    wr(OFS_RANGE, 32'd64);
    alarm <= 1'b1;
    low_batt <= 1'b1;
    start_diag();
    chk1(valid, 1'b0);
    rdchk(OFS_CMD_POS, 32'd132);
    rdchk(OFS_ERR, 32'hC1);
    batt_lost <= 1'b1;
    rdchk(OFS_ERR, 32'hC2);
    {alarm, low_batt, batt_lost} <= 3'h0;
    $display("test faults done");
    do_reset(1'b0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_OFFSET, 32'hFFFF_FFF0);
    start_diag();
    chk1(valid, 1'b1);
    rdchk(OFS_ACT_POS, enc.pos + 32'hFFFF_FFF0);
    // changed configuration blocks the restore, zero default allowed
    do_reset(1'b0);
    wr(OFS_CTRL, 32'h1);
    cfg_chg <= 1'b1;
    start_diag();
    chk1(valid, 1'b0);
    rdchk(OFS_ACT_POS, 32'h0);
    rdchk(OFS_CMD_POS, 32'h0);
    cfg_chg <= 1'b0;
    $display("test restore done");
    finish_test();
  end
endmodule
